//--- logic/rx_los_mute_regs.svh
/*
  Register offsets, field positions, reset values and fixed codes for the
  receive mute-on-loss control block.
  Assumes a byte-addressed Avalon-MM slave port with one 32-bit word per register.
*/
`ifndef RX_LOS_MUTE_REGS_SVH
`define RX_LOS_MUTE_REGS_SVH

// Register byte offsets
`define RLM_CTRL_OFS        4'h0
`define RLM_STATUS_OFS      4'h4
`define RLM_MASK_OFS        4'h8
`define RLM_STATE_OFS       4'hc

// Control fields
`define RLM_CTRL_MUTE_BIT   0
`define RLM_CTRL_EDGE_BIT   1
`define RLM_CTRL_WIDTH      2
`define RLM_CTRL_RESET      2'h0

// Status and mask layout: [2:0] loss declared, [5:3] loss cleared
`define RLM_EVT_WIDTH       6
`define RLM_EVT_RESET       6'h00
`define RLM_EVT_SET_LSB     0
`define RLM_EVT_CLR_LSB     3

// State register fields
`define RLM_STATE_LOS_LSB   0
`define RLM_STATE_MUTE_LSB  3
`define RLM_STATE_HOST_BIT  6
`define RLM_STATE_THRA_BIT  7
`define RLM_STATE_THRS_BIT  8

// Threshold set used when no channel runs at DS3 or STS-1
`define RLM_THR_DEFAULT     1'b0

`endif

//--- logic/rx_los_mute_pkg.sv
/*
  Types shared by the receive mute-on-loss control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rx_los_mute_pkg;

  // Per-channel line rate, as strapped or configured
  typedef enum logic [1:0]
  {
    RATE_E3   = 2'b00,
    RATE_DS3  = 2'b01,
    RATE_STS1 = 2'b10,
    RATE_RSVD = 2'b11
  } line_rate_e;

endpackage

//--- logic/rx_channel_mute.sv
/*
  One receive channel: retimes recovered data onto the chosen edge of the
  recovered clock and forces both rails low during signal loss when muting is on.
  Assumes recovered clock, data and loss level arrive from another domain.
*/
`timescale 1ns/1ps
`include "rx_los_mute_regs.svh"

module rx_channel_mute
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Recovered line signals (asynchronous)
  input  wire logic rclk_i,
  input  wire logic rpos_i,
  input  wire logic rneg_i,
  input  wire logic signal_loss_defect_i,
  // Configuration
  input  wire logic edge_falling_i,
  input  wire logic mute_en_i,
  // Outputs
  output logic      rx_positive_data_out_o,
  output logic      rx_negative_data_out_o,
  output logic      los_o,
  output logic      mute_active_o,
  output logic      los_declared_o,
  output logic      los_cleared_o
);

  logic [3:0] meta;
  logic [3:0] sync;
  logic       rclk_prev;
  logic       rclk_s;
  logic       rpos_s;
  logic       rneg_s;
  logic       los_s;
  logic       edge_evt;
  logic       mute_now;

  assign {rclk_s, rpos_s, rneg_s, los_s} = sync;
  assign edge_evt = edge_falling_i ? (rclk_prev & ~rclk_s) : (~rclk_prev & rclk_s);
  assign mute_now = mute_en_i & los_s;

  // Clock and data share one synchroniser so they stay aligned
  always_ff @(posedge clock_i)
  begin
    meta      <= {rclk_i, rpos_i, rneg_i, signal_loss_defect_i};
    sync      <= meta;
    rclk_prev <= rclk_s;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rx_positive_data_out_o <= 1'b0;
      rx_negative_data_out_o <= 1'b0;
      los_o                  <= 1'b0;
      mute_active_o          <= 1'b0;
    end
    else if (edge_evt)
    begin
      rx_positive_data_out_o <= rpos_s & ~mute_now;
      rx_negative_data_out_o <= rneg_s & ~mute_now;
      los_o                  <= los_s;
      mute_active_o          <= mute_now;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      los_declared_o <= 1'b0;
      los_cleared_o  <= 1'b0;
    end
    else
    begin
      los_declared_o <= edge_evt & los_s & ~los_o;
      los_cleared_o  <= edge_evt & ~los_s & los_o;
    end
  end

  mute_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    edge_evt && mute_en_i && los_s |=> !rx_positive_data_out_o && !rx_negative_data_out_o)
    else $error("Rails not muted during signal loss");

  pass_data_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    edge_evt && !mute_en_i |=> rx_positive_data_out_o == $past(rpos_s)
      && rx_negative_data_out_o == $past(rneg_s))
    else $error("Recovered data altered while muting is off");

  edge_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !edge_evt |=> $stable(rx_positive_data_out_o) && $stable(rx_negative_data_out_o))
    else $error("Data rails changed off the recovered clock edge");

  los_retime_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    edge_evt |=> los_o == $past(los_s) ##1 (edge_evt || $stable(los_o)))
    else $error("Loss level not retimed to recovered clock");

endmodule

//--- logic/rx_los_mute_control.sv
/*
  Global receive control for a three-channel line interface: mute-on-loss,
  loss threshold set selection and the shared mute-enable / interrupt pin.
  Assumes an Avalon-MM master with waitrequest on clock_i and asynchronous pins.
*/
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "rx_los_mute_regs.svh"

//Contract
//- With muting enabled, a channel holds both data rails low for as long as it declares loss.
//- With muting disabled, recovered data passes unchanged even during loss.
//- In host mode the mute pin is no longer read and instead drives the interrupt request.
//- One mute setting governs all three channels, with no per-channel pin enable.
//- The threshold select input picks one of two loss threshold sets for all channels.
//- The threshold select input counts only if some channel runs at DS3 or STS-1.
//- Data rails update only on the selected edge of the channel's recovered clock.
module rx_los_mute_control
#(
  parameter int CHANNELS = 3
)
(
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Mode and configuration pins
  input  wire logic                  host_mode_i,
  input  wire logic                  loss_threshold_select_i,
  input  wire logic [2*CHANNELS-1:0] channel_rate_i,
  // Shared mute-enable / interrupt pin, open drain in host mode
  input  wire logic                  mute_on_loss_enable_i,
  output logic                       mute_on_loss_enable_o,
  output logic                       mute_on_loss_enable_oe_o,
  // Recovered line signals per channel
  input  wire logic [CHANNELS-1:0]   rclk_i,
  input  wire logic [CHANNELS-1:0]   rpos_i,
  input  wire logic [CHANNELS-1:0]   rneg_i,
  input  wire logic [CHANNELS-1:0]   signal_loss_defect_i,
  // Outputs to framer and analog detector
  output logic      [CHANNELS-1:0]   rx_positive_data_out_o,
  output logic      [CHANNELS-1:0]   rx_negative_data_out_o,
  output logic                       threshold_set_high_o,
  output logic                       threshold_select_active_o,
  // Interrupt
  output logic                       irq_o
);

  localparam int CFG_BITS = 3 + 2 * CHANNELS;

  function automatic logic rate_is_fast(input logic [1:0] rate);
    rate_is_fast = (rate == 2'(rx_los_mute_pkg::RATE_DS3))
                || (rate == 2'(rx_los_mute_pkg::RATE_STS1));
  endfunction

  // Pin synchronisers
  logic [CFG_BITS-1:0]   cfg_meta;
  logic [CFG_BITS-1:0]   cfg_sync;
  logic                  host_s;
  logic                  thr_s;
  logic                  pin_mute_s;
  logic [2*CHANNELS-1:0] rate_s;

  // Registers
  logic [`RLM_CTRL_WIDTH-1:0] ctrl;
  logic [`RLM_EVT_WIDTH-1:0]  status;
  logic [`RLM_EVT_WIDTH-1:0]  mask;
  logic                       ack;

  // Channel results
  logic [CHANNELS-1:0] los_q;
  logic [CHANNELS-1:0] mute_q;
  logic [CHANNELS-1:0] los_set;
  logic [CHANNELS-1:0] los_clr;
  logic [CHANNELS-1:0] fast_ch;

  // Decode
  wire                       req        = avs_read_i | avs_write_i;
  wire                       ofs_ctrl   = avs_address_i[3:2] == `RLM_CTRL_OFS >> 2;
  wire                       ofs_status = avs_address_i[3:2] == `RLM_STATUS_OFS >> 2;
  wire                       ofs_mask   = avs_address_i[3:2] == `RLM_MASK_OFS >> 2;
  wire                       ofs_state  = avs_address_i[3:2] == `RLM_STATE_OFS >> 2;
  wire                       wr_take    = avs_write_i & ack & avs_byteenable_i[0];
  wire [`RLM_EVT_WIDTH-1:0]  evt_set    = {los_clr, los_set};
  wire [`RLM_EVT_WIDTH-1:0]  evt_clr    = (wr_take & ofs_status)
                                          ? avs_writedata_i[`RLM_EVT_WIDTH-1:0]
                                          : `RLM_EVT_RESET;
  wire                       any_fast   = |fast_ch;
  wire                       irq_pend   = |(status & mask);
  wire                       mute_eff   = host_s ? ctrl[`RLM_CTRL_MUTE_BIT] : pin_mute_s;
  wire [31:0]                state_word;
  wire [31:0]                rd_word;

  assign {host_s, thr_s, pin_mute_s, rate_s} = cfg_sync;
  assign avs_waitrequest_o = req & ~ack;
  assign mute_on_loss_enable_o = 1'b0;

  assign state_word = {23'h000000,
                       thr_s,
                       threshold_select_active_o,
                       host_s,
                       mute_q,
                       los_q};

  assign rd_word = ofs_ctrl   ? {30'h00000000, ctrl}   :
                   ofs_status ? {26'h0000000, status}  :
                   ofs_mask   ? {26'h0000000, mask}    :
                   ofs_state  ? state_word             :
                                32'h00000000;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      assign fast_ch[g] = rate_is_fast(rate_s[2*g +: 2]);

      // Every channel sees the same mute enable; no per-channel pin control
      rx_channel_mute u_ch
      (
        .clock_i                (clock_i),
        .rst_n_i                (rst_n_i),
        .rclk_i                 (rclk_i[g]),
        .rpos_i                 (rpos_i[g]),
        .rneg_i                 (rneg_i[g]),
        .signal_loss_defect_i   (signal_loss_defect_i[g]),
        .edge_falling_i         (ctrl[`RLM_CTRL_EDGE_BIT]),
        .mute_en_i              (mute_eff),
        .rx_positive_data_out_o (rx_positive_data_out_o[g]),
        .rx_negative_data_out_o (rx_negative_data_out_o[g]),
        .los_o                  (los_q[g]),
        .mute_active_o          (mute_q[g]),
        .los_declared_o         (los_set[g]),
        .los_cleared_o          (los_clr[g])
      );
    end
  endgenerate

  // Strap pins may move at any time, so all pass two flops
  always_ff @(posedge clock_i)
  begin
    cfg_meta <= {host_mode_i, loss_threshold_select_i, mute_on_loss_enable_i, channel_rate_i};
    cfg_sync <= cfg_meta;
  end

  // One wait state; read data is registered with the acknowledge
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      ack            <= req & ~ack;
      avs_readdata_o <= (avs_read_i & ~ack) ? rd_word : avs_readdata_o;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= `RLM_CTRL_RESET;
      mask <= `RLM_EVT_RESET;
    end
    else
    begin
      if (wr_take & ofs_ctrl)
        ctrl <= avs_writedata_i[`RLM_CTRL_WIDTH-1:0];
      if (wr_take & ofs_mask)
        mask <= avs_writedata_i[`RLM_EVT_WIDTH-1:0];
    end
  end

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      status <= `RLM_EVT_RESET;
    else
      status <= (status & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      irq_o                     <= 1'b0;
      mute_on_loss_enable_oe_o  <= 1'b0;
      threshold_set_high_o      <= `RLM_THR_DEFAULT;
      threshold_select_active_o <= 1'b0;
    end
    else
    begin
      irq_o                     <= irq_pend;
      mute_on_loss_enable_oe_o  <= host_s & irq_pend;
      threshold_set_high_o      <= any_fast ? thr_s : `RLM_THR_DEFAULT;
      threshold_select_active_o <= any_fast;
    end
  end

  host_irq_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    host_s && irq_pend |=> mute_on_loss_enable_oe_o && !mute_on_loss_enable_o)
    else $error("Host mode interrupt not driven on the mute pin");

  hw_pin_input_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !host_s |=> !mute_on_loss_enable_oe_o)
    else $error("Mute pin driven outside host mode");

  global_mute_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !host_s && !pin_mute_s |-> !mute_eff ##1 ((mute_q & ~$past(mute_q)) == {CHANNELS{1'b0}}))
    else $error("A channel muted although the shared enable is low");

  thr_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    any_fast |=> threshold_set_high_o == $past(thr_s) && threshold_select_active_o)
    else $error("Threshold set does not follow the select input");

  thr_ignore_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !any_fast |=> threshold_set_high_o == `RLM_THR_DEFAULT && !threshold_select_active_o)
    else $error("Threshold select acted on with no DS3 or STS-1 channel");

  irq_level_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_pend |=> irq_o)
    else $error("Interrupt output missing for pending event");

  bus_answer_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req && !ack |=> !avs_waitrequest_o || !req)
    else $error("Bus request not answered after one wait state");

endmodule

//--- verif/line_source.sv
/*
  Recovered line source: one recovered clock shared by three channels, dual rails.
  Assumes clock_i at least eight times the recovered rate.
*/
`timescale 1ns/1ps

module line_source
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Recovered line
  output logic      [2:0] rclk_o,
  output logic      [2:0] rpos_o,
  output logic      [2:0] rneg_o
);
  logic [2:0] phase;
  logic [5:0] pattern;

  // Rails move mid high phase, so either recovered edge sees settled data
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      phase   <= 3'h0;
      pattern <= 6'h00;
    end
    else
    begin
      phase <= phase + 3'h1;
      if (phase == 3'h5)
      begin
        pattern <= pattern + 6'h0b;
      end
    end
  end

  assign rclk_o = {3{phase[2]}};
  assign rpos_o = pattern[2:0];
  assign rneg_o = pattern[5:3];
endmodule

//--- verif/testbench.sv
/*
  Self-checking bench for the receive mute-on-loss control block.
  Assumes the line source model beside it and the register header on the include path.
*/
`timescale 1ns/1ps
`include "rx_los_mute_regs.svh"

module testbench;
  logic        clock_i, rst_n_i, avs_read, avs_write, host_mode, thr_sel, mute_pin;
  logic        avs_wait, pin_o, pin_oe, pin_wire, thr_high, thr_active, irq;
  logic        ctrl_mute, edge_fall, prev_rclk, mute_eff;
  logic [3:0]  avs_address, avs_be;
  logic [31:0] avs_wdata, avs_rdata, rd, saved;
  logic [5:0]  rate, cfg_q;
  logic [2:0]  rclk, rpos, rneg, los, out_p, out_n, exp_p, exp_n;
  logic [8:0]  rows [8];
  int          fail_count, total_checks, cycles, quiet, due;

  // Open-drain pin: low while the block drives it, strap level otherwise
  assign pin_wire = pin_oe ? pin_o : mute_pin;
  assign mute_eff = host_mode ? ctrl_mute : mute_pin;

  line_source u_src (.clock_i(clock_i), .rst_n_i(rst_n_i), .rclk_o(rclk), .rpos_o(rpos),
                     .rneg_o(rneg));

  rx_los_mute_control #(.CHANNELS(3)) u_dut
  (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(avs_be), .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait),
    .host_mode_i(host_mode), .loss_threshold_select_i(thr_sel), .channel_rate_i(rate),
    .mute_on_loss_enable_i(pin_wire), .mute_on_loss_enable_o(pin_o),
    .mute_on_loss_enable_oe_o(pin_oe), .rclk_i(rclk), .rpos_i(rpos), .rneg_i(rneg),
    .signal_loss_defect_i(los), .rx_positive_data_out_o(out_p),
    .rx_negative_data_out_o(out_n), .threshold_set_high_o(thr_high),
    .threshold_select_active_o(thr_active), .irq_o(irq)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data,
                     input logic [3:0] be);
    @(posedge clock_i);
    avs_read    <= !wr;
    avs_write   <= wr;
    avs_address <= addr;
    avs_wdata   <= data;
    avs_be      <= be;
    @(posedge clock_i);
    while (avs_wait !== 1'b0)
    begin
      @(posedge clock_i);
    end
    rd = avs_rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic set_ctrl(input logic m, input logic e);
    bus(1'b1, `RLM_CTRL_OFS, {30'h0, e, m}, 4'hf);
    ctrl_mute <= m;
    edge_fall <= e;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Rails judged only once inputs have been quiet, so sync skew cannot race
  always @(posedge clock_i)
  begin
    prev_rclk <= rclk[0];
    cfg_q     <= {rst_n_i, los, mute_eff, edge_fall};
    quiet     <= (cfg_q != {rst_n_i, los, mute_eff, edge_fall}) ? 0 : quiet + 1;
    cycles    <= cycles + 1;
    // Skip a prediction overtaken by a config change inside its window
    if (due == 1 && quiet > 7)
      check("rails", {26'h0, out_n, out_p}, {26'h0, exp_n, exp_p});
    if (due > 0)
      due <= due - 1;
    if (quiet > 10 && (edge_fall ? (prev_rclk && !rclk[0]) : (!prev_rclk && rclk[0])))
    begin
      exp_p <= mute_eff ? (rpos & ~los) : rpos;
      exp_n <= mute_eff ? (rneg & ~los) : rneg;
      due   <= 6;
    end
    if (cycles == 6000)
    begin
      fail_count++;
      end_sim;
    end
  end

  initial
  begin
    rst_n_i = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_wdata = 32'h0; avs_be = 4'h0; host_mode = 1'b0; thr_sel = 1'b0; mute_pin = 1'b0;
    rate = 6'h00; los = 3'h0; ctrl_mute = 1'b0; edge_fall = 1'b0; prev_rclk = 1'b0;
    fail_count = 0; total_checks = 0; cycles = 0; quiet = 0; due = 0;
    // Rows: channel rates, select pin, expected set and active flag
    rows = '{9'h004, 9'h00f, 9'h009, 9'h047, 9'h101, 9'h1fc, 9'h01c, 9'h087};
    idle(10);
    rst_n_i <= 1'b1;
    idle(3);
    for (int a = 0; a < 3; a++)
    begin
      bus(1'b0, 4'(a * 4), 32'h0, 4'hf);
      check("reset value", rd, 32'h0);
    end
    for (int r = 0; r < 8; r++)
    begin
      rate    <= rows[r][8:3];
      thr_sel <= rows[r][2];
      idle(6);
      check("threshold", {30'h0, thr_high, thr_active}, {30'h0, rows[r][1:0]});
    end
    mute_pin <= 1'b1;
    los      <= 3'b101;
    idle(40);
    mute_pin <= 1'b0;
    los      <= 3'b111;
    idle(40);
    set_ctrl(1'b0, 1'b1);
    mute_pin <= 1'b1;
    los      <= 3'b010;
    idle(40);
    set_ctrl(1'b0, 1'b0);
    host_mode <= 1'b1;
    los       <= 3'b000;
    idle(40);
    bus(1'b1, `RLM_STATUS_OFS, 32'h3f, 4'hf);
    los <= 3'b001;
    idle(40);
    bus(1'b0, `RLM_STATUS_OFS, 32'h0, 4'hf);
    check("status declared", rd, 32'h1);
    check("irq idle", {29'h0, irq, pin_oe, pin_wire}, 32'h1);
    bus(1'b1, `RLM_MASK_OFS, 32'h1, 4'hf);
    idle(3);
    check("irq raised", {29'h0, irq, pin_oe, pin_wire}, 32'h6);
    // Byte 0 disabled, so the clear must not land
    bus(1'b1, `RLM_STATUS_OFS, 32'h1, 4'h0);
    idle(3);
    check("irq kept", {31'h0, irq}, 32'h1);
    bus(1'b1, `RLM_STATUS_OFS, 32'h1, 4'hf);
    idle(3);
    check("irq cleared", {29'h0, irq, pin_oe, pin_wire}, 32'h1);
    set_ctrl(1'b1, 1'b0);
    idle(40);
    los <= 3'b000;
    idle(40);
    bus(1'b0, `RLM_STATUS_OFS, 32'h0, 4'hf);
    check("status cleared", rd, 32'h8);
    bus(1'b0, `RLM_STATE_OFS, 32'h0, 4'hf);
    saved = rd;
    check("host flag", {31'h0, saved[`RLM_STATE_HOST_BIT]}, 32'h1);
    bus(1'b1, `RLM_STATE_OFS, 32'h1ff, 4'hf);
    bus(1'b0, `RLM_STATE_OFS, 32'h0, 4'hf);
    check("state read only", rd, saved);
    end_sim;
  end
endmodule
